// ===== rtl/wcthr_regs.sv
// Behaviour
// - High limit upper byte compares against result bits 11:4.
// - High limit lower nibble lines up with result bits 3:0.
// - Low limit lower nibble lines up with result bits 3:0.
// - Low limit upper byte compares against result bits 11:4.
// - Deadband nibble shifted left three, applied to both limits.
// - Alert only after n+1 consecutive crossing samples.
// - Event filter register: low nibble 7-4, count 3-0, resets zero.
// - Deadband register: high nibble 7-4 resets ones, deadband 3-0 zero.
// - High limit upper byte resets to all ones.
// - Low limit upper byte resets to zero.
// - Four bytes per channel: deadband, high upper, filter, low upper.
// - Channel 6 low limit upper byte at index 0x3B, resets zero.
//
// Purpose: Threshold register bank for channels 4 to 6 with AHB-Lite slave.
// Assumes: Single word transfers; always OKAY, zero wait states.
// Notes: Channel 4 high bytes and channel 6 low byte sit outside the window.
`timescale 1ns/1ps
module wcthr_regs import wcthr_pkg::*; #(
    parameter int RES_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sampleValid,
    input wire logic [1:0] sampleChan,
    input wire logic [RES_W-1:0] sampleData,
    output logic irq
);
    initial begin
        if (RES_W != 12) $error("wcthr_regs serves 12-bit results only");
    end

    // Per-channel register storage, channel index 0..2 means 4..6
    logic [7:0] deadbandReg_r [NUM_CH];
    logic [7:0] highUpper_r [NUM_CH];
    logic [7:0] filterReg_r [NUM_CH];
    logic [7:0] lowUpper_r [NUM_CH];
    logic [2*NUM_CH-1:0] irqEnable_r;
    logic [2*NUM_CH-1:0] irqStatus;
    logic [2*NUM_CH-1:0] irqClear;
    logic [2*NUM_CH-1:0] chanEvents;
    logic irqLine;
    logic wrPend_r;
    logic [7:0] wrIdx_r;
    logic fwdWr;
    logic addrPhase;
    logic [7:0] reqIdx;
    logic [NUM_CH-1:0] chanValid;

    // Word index of a byte address; upper bits must be zero to hit
    function automatic logic [7:0] word_index(input logic [31:0] a);
        return (a[31:10] == 22'h000000) ? a[9:2] : 8'hFF;
    endfunction : word_index

    // Read word of a byte register; a write still in its data phase is passed on
    function automatic logic [31:0] rd_byte(input logic fwd, input logic [7:0] wrByte, input logic [7:0] held);
        return {24'h000000, fwd ? wrByte : held};
    endfunction : rd_byte

    assign addrPhase = hsel && hready && htrans[1];
    assign reqIdx = word_index(haddr);
    // Back-to-back write then read of one place would otherwise return stale data
    assign fwdWr = wrPend_r && wrIdx_r == reqIdx;

    // Capture address phase; data follows next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrIdx_r <= 8'h00;
        end else if (hready) begin
            wrPend_r <= addrPhase && hwrite;
            wrIdx_r <= reqIdx;
        end
    end

    // Zero wait states, never an error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Register writes; ch4 deadband/high and ch6 low come from neighbours
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                deadbandReg_r[c] <= RST_HYS;
                highUpper_r[c] <= RST_HIGH;
                filterReg_r[c] <= RST_EVT;
                lowUpper_r[c] <= RST_LOW;
            end
            irqEnable_r <= '0;
        end else if (wrPend_r) begin
            // Thresholds only change on host writes
            unique case (wrIdx_r)
                IDX_CH4_HYS_IN: deadbandReg_r[0] <= hwdata[7:0];
                IDX_CH4_HIGH_IN: highUpper_r[0] <= hwdata[7:0];
                IDX_CH4_EVT: filterReg_r[0] <= hwdata[7:0];
                IDX_CH4_LOW: lowUpper_r[0] <= hwdata[7:0];
                IDX_CH5_HYS: deadbandReg_r[1] <= hwdata[7:0];
                IDX_CH5_HIGH: highUpper_r[1] <= hwdata[7:0];
                IDX_CH5_EVT: filterReg_r[1] <= hwdata[7:0];
                IDX_CH5_LOW: lowUpper_r[1] <= hwdata[7:0];
                IDX_CH6_HYS: deadbandReg_r[2] <= hwdata[7:0];
                IDX_CH6_HIGH: highUpper_r[2] <= hwdata[7:0];
                IDX_CH6_EVT: filterReg_r[2] <= hwdata[7:0];
                IDX_CH6_LOW, IDX_CH6_LOW_IN: lowUpper_r[2] <= hwdata[7:0];
                IDX_IRQ_EN: irqEnable_r <= hwdata[2*NUM_CH-1:0];
                default: ;
            endcase
        end
    end

    // Clear pulses for the write-only clear register
    assign irqClear = (wrPend_r && wrIdx_r == IDX_IRQ_CLR) ? hwdata[2*NUM_CH-1:0] : '0;

    // Read data registered straight out of the index decode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            unique case (reqIdx)
                IDX_CH4_HYS_IN: hrdata <= rd_byte(fwdWr, hwdata[7:0], deadbandReg_r[0]);
                IDX_CH4_HIGH_IN: hrdata <= rd_byte(fwdWr, hwdata[7:0], highUpper_r[0]);
                IDX_CH4_EVT: hrdata <= rd_byte(fwdWr, hwdata[7:0], filterReg_r[0]);
                IDX_CH4_LOW: hrdata <= rd_byte(fwdWr, hwdata[7:0], lowUpper_r[0]);
                IDX_CH5_HYS: hrdata <= rd_byte(fwdWr, hwdata[7:0], deadbandReg_r[1]);
                IDX_CH5_HIGH: hrdata <= rd_byte(fwdWr, hwdata[7:0], highUpper_r[1]);
                IDX_CH5_EVT: hrdata <= rd_byte(fwdWr, hwdata[7:0], filterReg_r[1]);
                IDX_CH5_LOW: hrdata <= rd_byte(fwdWr, hwdata[7:0], lowUpper_r[1]);
                IDX_CH6_HYS: hrdata <= rd_byte(fwdWr, hwdata[7:0], deadbandReg_r[2]);
                IDX_CH6_HIGH: hrdata <= rd_byte(fwdWr, hwdata[7:0], highUpper_r[2]);
                IDX_CH6_EVT: hrdata <= rd_byte(fwdWr, hwdata[7:0], filterReg_r[2]);
                IDX_CH6_LOW, IDX_CH6_LOW_IN: hrdata <= rd_byte(fwdWr, hwdata[7:0], lowUpper_r[2]);
                IDX_IRQ_STAT: hrdata <= {26'h0, irqStatus};
                IDX_IRQ_EN: hrdata <= {26'h0, fwdWr ? hwdata[2*NUM_CH-1:0] : irqEnable_r};
                default: hrdata <= 32'h00000000; // Unmapped and clear read as zero
            endcase
        end
    end

    // Steer the sample to its channel
    always_comb begin
        chanValid = '0;
        if (sampleValid && sampleChan < 2'(NUM_CH)) chanValid[sampleChan] = 1'b1;
    end

    // One comparator per channel; fields pulled out per combined register
    for (genvar c = 0; c < NUM_CH; c++) begin : gChan
        wcthr_chan #(.RES_W(RES_W)) uChan (
            .clk(clk),
            .rst(rst),
            .sampleValid(chanValid[c]),
            .sample(sampleData),
            .highUpper(highUpper_r[c]),
            .highLower(deadbandReg_r[c][NIB_HI_LSB +: 4]),
            .lowUpper(lowUpper_r[c]),
            .lowLower(filterReg_r[c][NIB_HI_LSB +: 4]),
            .deadband(deadbandReg_r[c][NIB_LO_LSB +: 4]),
            .eventCount(filterReg_r[c][NIB_LO_LSB +: 4]),
            .highEvent(chanEvents[2*c]),
            .lowEvent(chanEvents[2*c+1])
        );
    end

    // Sticky alert flags and interrupt line
    wcthr_irq #(.N(2*NUM_CH)) uIrq (
        .clk(clk),
        .rst(rst),
        .events(chanEvents),
        .clearMask(irqClear),
        .enable(irqEnable_r),
        .status(irqStatus),
        .irq(irqLine)
    );

    // Output straight from the flop inside the irq module
    assign irq = irqLine;
endmodule : wcthr_regs

// ===== pkg/wcthr_pkg.sv
// Purpose: Shared constants for the window comparator threshold register bank.
// Assumes: 8-bit registers, each on one aligned 32-bit AHB-Lite word.
// Notes: Printed offsets are not all multiples of four, so they are word indices.
package wcthr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CH4_EVT = 8'h32;
    localparam logic [7:0] IDX_CH4_LOW = 8'h33;
    localparam logic [7:0] IDX_CH5_HYS = 8'h34;
    localparam logic [7:0] IDX_CH5_HIGH = 8'h35;
    localparam logic [7:0] IDX_CH5_EVT = 8'h36;
    localparam logic [7:0] IDX_CH5_LOW = 8'h37;
    localparam logic [7:0] IDX_CH6_HYS = 8'h38;
    localparam logic [7:0] IDX_CH6_HIGH = 8'h39;
    localparam logic [7:0] IDX_CH6_EVT = 8'h3A;
    localparam logic [7:0] IDX_CH6_LOW = 8'h3B;
    // Block-level registers and relocated channel bytes at indices of our own
    localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h41;
    localparam logic [7:0] IDX_IRQ_EN = 8'h42;
    localparam logic [7:0] IDX_CH4_HIGH_IN = 8'h43;
    localparam logic [7:0] IDX_CH4_HYS_IN = 8'h44;
    localparam logic [7:0] IDX_CH6_LOW_IN = 8'h45;
    // Reset values
    localparam logic [7:0] RST_HYS = 8'hF0;
    localparam logic [7:0] RST_HIGH = 8'hFF;
    localparam logic [7:0] RST_EVT = 8'h00;
    localparam logic [7:0] RST_LOW = 8'h00;
    // Field positions inside combined registers
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_LO_LSB = 0;
    localparam int HYS_SHIFT = 3;
    // Status bit positions: alert high then alert low per channel
    localparam int NUM_CH = 3;
endpackage : wcthr_pkg

// ===== rtl/wcthr_chan.sv
// Purpose: One channel of the digital window comparator with event filter.
// Assumes: Thresholds come from registers held steady by the register bank.
// Notes: Hysteresis re-arms the same crossing only after leaving the band.
`timescale 1ns/1ps
module wcthr_chan import wcthr_pkg::*; #(
    parameter int RES_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sampleValid,
    input wire logic [RES_W-1:0] sample,
    input wire logic [7:0] highUpper,
    input wire logic [3:0] highLower,
    input wire logic [7:0] lowUpper,
    input wire logic [3:0] lowLower,
    input wire logic [3:0] deadband,
    input wire logic [3:0] eventCount,
    output logic highEvent,
    output logic lowEvent
);
    initial begin
        if (RES_W != 12) $error("wcthr_chan serves 12-bit results only");
    end

    logic [11:0] highLimit;
    logic [11:0] lowLimit;
    logic [6:0] band;
    logic [4:0] highRun_r;
    logic [4:0] lowRun_r;
    logic highArmed_r;
    logic lowArmed_r;
    logic overHigh;
    logic underLow;
    logic [12:0] highRel;
    logic [12:0] lowRel;

    // Assemble thresholds: upper byte on result bits 11:4, nibble on 3:0
    assign highLimit = {highUpper, highLower};
    assign lowLimit = {lowUpper, lowLower};
    assign band = {deadband, 3'b000};
    // Unsigned compares; the band is added to the sample for high and to the limit for low so nothing wraps below zero
    assign overHigh = sample > highLimit;
    assign underLow = sample < lowLimit;
    assign highRel = {1'b0, sample} + {6'h00, band};
    assign lowRel = {1'b0, lowLimit} + {6'h00, band};

    // Count consecutive crossings; event fires on the n+1th
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            highRun_r <= 5'h00;
            lowRun_r <= 5'h00;
            highEvent <= 1'b0;
            lowEvent <= 1'b0;
        end else begin
            highEvent <= 1'b0;
            lowEvent <= 1'b0;
            if (sampleValid) begin
                highRun_r <= (overHigh && highArmed_r) ? highRun_r + 5'h01 : 5'h00;
                lowRun_r <= (underLow && lowArmed_r) ? lowRun_r + 5'h01 : 5'h00;
                if (overHigh && highArmed_r && highRun_r == {1'b0, eventCount}) begin
                    highEvent <= 1'b1;
                end
                if (underLow && lowArmed_r && lowRun_r == {1'b0, eventCount}) begin
                    lowEvent <= 1'b1;
                end
            end
        end
    end

    // Re-arm after the result comes back past the hysteresis band
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            highArmed_r <= 1'b1;
            lowArmed_r <= 1'b1;
        end else if (sampleValid) begin
            if (highEvent) highArmed_r <= 1'b0;
            else if (highRel < {1'b0, highLimit}) highArmed_r <= 1'b1;
            if (lowEvent) lowArmed_r <= 1'b0;
            else if ({1'b0, sample} > lowRel) lowArmed_r <= 1'b1;
        end else begin
            if (highEvent) highArmed_r <= 1'b0;
            if (lowEvent) lowArmed_r <= 1'b0;
        end
    end
endmodule : wcthr_chan

// ===== rtl/wcthr_irq.sv
// Purpose: Sticky event status with enable gating and write-one clear.
// Assumes: Events are one-cycle pulses on the same clock.
// Notes: A set in the clearing cycle wins so no event is lost.
`timescale 1ns/1ps
module wcthr_irq #(
    parameter int N = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [N-1:0] events,
    input wire logic [N-1:0] clearMask,
    input wire logic [N-1:0] enable,
    output logic [N-1:0] status,
    output logic irq
);
    initial begin
        if (N < 1 || N > 32) $error("wcthr_irq width out of range");
    end

    // Sticky status: set dominates clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) status <= '0;
        else status <= (status & ~clearMask) | events;
    end

    // Level interrupt from enabled status, registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) irq <= 1'b0;
        else irq <= |(((status & ~clearMask) | events) & enable);
    end
endmodule : wcthr_irq

// ===== sim/wcthr_regs_properties.sv
// Purpose: Bus and interrupt properties for the threshold register bank.
// Assumes: Single word transfers, one slave, hready fed back from hreadyout.
// Notes: Interrupt edges are traced back to a recent sample or write.
`timescale 1ns/1ps
module wcthr_regs_props import wcthr_pkg::*; #(
    parameter int RES_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sampleValid,
    input wire logic [1:0] sampleChan,
    input wire logic [RES_W-1:0] sampleData,
    input wire logic irq
);
    // Decoded address phase
    wire take = hsel && hready && htrans[1];
    wire [7:0] idx = haddr[9:2];
    wire mapped = haddr[31:10] == 22'h0 && idx >= IDX_CH4_EVT && idx <= IDX_CH6_LOW_IN;
    logic [3:0] svHist_r;
    logic [3:0] wrHist_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Recent samples and writes, the only causes of an interrupt change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            svHist_r <= 4'h0;
            wrHist_r <= 4'h0;
        end else begin
            svHist_r <= {svHist_r[2:0], sampleValid};
            wrHist_r <= {wrHist_r[2:0], take && hwrite};
        end
    end
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not OKAY");
    property p_ready; hreadyout == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_upper; hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data above byte");
    property p_unmap; take && !hwrite && !mapped |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !(take && !hwrite) |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rise; $rose(irq) |-> (|svHist_r) || (|wrHist_r); endproperty
    a_rise: assert property (p_rise) else $error("irq rose without cause");
    property p_fall; $fell(irq) |-> |wrHist_r; endproperty
    a_fall: assert property (p_fall) else $error("irq fell without write");
    property p_clean; $fell(rst) |-> !irq && hrdata == 32'h0; endproperty
    a_clean: assert property (p_clean) else $error("outputs not idle after reset");
endmodule : wcthr_regs_props

bind wcthr_regs wcthr_regs_props #(.RES_W(RES_W)) wcthr_regs_props_i (.clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .sampleValid, .sampleChan, .sampleData, .irq);

// ===== sim/wcthr_host.sv
// Purpose: Host model issuing single word AHB-Lite transfers.
// Assumes: One slave; the master waits on hready with no fixed latency.
// Notes: Write data is inverted once its phase ends so stale data never looks valid.
`timescale 1ns/1ps
module wcthr_host (
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~{24'h0, d};
    endtask : xfer
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        xfer(1'b0, idx, 8'h00, q);
    endtask : rd
endmodule : wcthr_host

// ===== sim/wcthr_regs_tb.sv
// Purpose: Self-checking bench for the threshold register bank.
// Assumes: Host model drives the bus; samples come from here.
// Notes: Thresholds are set only through bus writes.
`timescale 1ns/1ps
module wcthr_regs_tb import wcthr_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sampleValid = 1'b0;
    logic [1:0] sampleChan = 2'h0;
    logic [11:0] sampleData = 12'h000;
    logic hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    int errorCnt = 0;
    int checksDone = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    wcthr_regs #(.RES_W(12)) wcthr_regs_i (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sampleValid, .sampleChan, .sampleData, .irq);
    wcthr_host wcthr_host_i (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
        wcthr_host_i.rd(idx, rdv);
        chk(rdv, exp);
    endtask : rdChk
    // Samples with a quiet cycle between them
    task automatic smp(input logic [1:0] ch, input logic [11:0] d, input int n);
        repeat (n) begin
            sampleValid <= 1'b1;
            sampleChan <= ch;
            sampleData <= d;
            @(posedge clk);
            sampleValid <= 1'b0;
            @(posedge clk);
        end
    endtask : smp
    // Status and irq land two edges after the sample; four leaves margin
    task automatic irqChk(input logic exp);
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irqChk
    task automatic doReset;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : doReset
    task automatic stopTest;
        $display("TB: checks %0d, mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stopTest
    initial begin
        doReset();
        for (int i = 8'h32; i <= 8'h3B; i++)
            rdChk(8'(i), i % 4 == 0 ? 32'hF0 : i % 4 == 1 ? 32'hFF : 32'h0);
        rdChk(IDX_CH4_HIGH_IN, 32'hFF);
        rdChk(IDX_CH4_HYS_IN, 32'hF0);
        $display("TB: reset values done");
        // A distinct byte per place exposes any overlap; the unmapped place keeps nothing
        for (int i = 8'h32; i <= 8'h3B; i++)
            wcthr_host_i.wr(8'(i), 8'(i) ^ 8'hA5);
        wcthr_host_i.wr(8'h50, 8'h77);
        for (int i = 8'h32; i <= 8'h3B; i++)
            rdChk(8'(i), {24'h0, 8'(i) ^ 8'hA5});
        rdChk(8'h50, 32'h0);
        rdChk(IDX_CH6_LOW_IN, {24'h0, 8'h3B ^ 8'hA5});
        $display("TB: read-back done");
        doReset();
        // Ch5 high limit 0x805, deadband 8 codes, three crossings in a row
        wcthr_host_i.wr(IDX_CH5_HIGH, 8'h80);
        wcthr_host_i.wr(IDX_CH5_HYS, 8'h51);
        wcthr_host_i.wr(IDX_CH5_EVT, 8'h02);
        wcthr_host_i.wr(IDX_IRQ_EN, 8'h3F);
        smp(2'h1, 12'h806, 2);
        smp(2'h1, 12'h805, 1);
        smp(2'h1, 12'h806, 2);
        irqChk(1'b0);
        smp(2'h1, 12'h806, 1);
        irqChk(1'b1);
        rdChk(IDX_IRQ_STAT, 32'h04);
        wcthr_host_i.wr(IDX_IRQ_CLR, 8'h04);
        irqChk(1'b0);
        // 0x800 is inside the band and must not re-arm; 0x7FC is below it
        smp(2'h1, 12'h800, 1);
        smp(2'h1, 12'h806, 3);
        irqChk(1'b0);
        smp(2'h1, 12'h7FC, 1);
        smp(2'h1, 12'h806, 3);
        irqChk(1'b1);
        wcthr_host_i.wr(IDX_IRQ_CLR, 8'h04);
        $display("TB: high limit done");
        // Ch6 low limit 0x403, single sample, masked first
        wcthr_host_i.wr(IDX_CH6_LOW, 8'h40);
        wcthr_host_i.wr(IDX_CH6_EVT, 8'h30);
        wcthr_host_i.wr(IDX_IRQ_EN, 8'h1F);
        smp(2'h2, 12'h403, 1);
        irqChk(1'b0);
        smp(2'h2, 12'h402, 1);
        irqChk(1'b0);
        rdChk(IDX_IRQ_STAT, 32'h20);
        wcthr_host_i.wr(IDX_IRQ_EN, 8'h3F);
        irqChk(1'b1);
        wcthr_host_i.wr(IDX_IRQ_CLR, 8'h20);
        irqChk(1'b0);
        rdChk(IDX_IRQ_STAT, 32'h0);
        $display("TB: low limit done");
        // Ch4 high limit at indices of our own; a sample tagged channel 3 must go nowhere
        wcthr_host_i.wr(IDX_CH4_HIGH_IN, 8'h10);
        wcthr_host_i.wr(IDX_CH4_HYS_IN, 8'h00);
        wcthr_host_i.wr(IDX_CH4_LOW, 8'h20);
        wcthr_host_i.wr(IDX_CH4_EVT, 8'h80);
        smp(2'h3, 12'h101, 1);
        irqChk(1'b0);
        smp(2'h0, 12'h101, 1);
        smp(2'h0, 12'h207, 1);
        irqChk(1'b1);
        rdChk(IDX_IRQ_STAT, 32'h03);
        rdChk(IDX_IRQ_EN, 32'h3F);
        wcthr_host_i.wr(IDX_IRQ_CLR, 8'h03);
        irqChk(1'b0);
        $display("TB: channel 4 done");
        stopTest();
    end
    // Hang guard, far above the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        $display("BAD %0t: timeout", $time);
        stopTest();
    end
endmodule : wcthr_regs_tb
